/* verilog/synth_cfg_pkg.sv */
package synth_cfg_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int REG_W  = 8;

  // Register indices, used directly as bus addresses (no scaling by four)
  localparam logic [9:0] IDX_LOCK_STATE    = 10'h028;
  localparam logic [9:0] IDX_RSVD_29       = 10'h029;
  localparam logic [9:0] IDX_P_OUT_EN      = 10'h036;
  localparam logic [9:0] IDX_P_GEN         = 10'h037;
  localparam logic [9:0] IDX_P_MULT_LO     = 10'h038;
  localparam logic [9:0] IDX_P_MULT_HI     = 10'h039;
  localparam logic [9:0] IDX_P_CLK_COARSE  = 10'h03A;
  localparam logic [9:0] IDX_P_FINE_ALIGN  = 10'h03D;
  localparam logic [9:0] IDX_P_RATE        = 10'h03E;
  localparam logic [9:0] IDX_P_STYLE       = 10'h03F;
  localparam logic [9:0] IDX_P_FDLY_LO     = 10'h040;
  localparam logic [9:0] IDX_P_FDLY_HI     = 10'h041;
  localparam logic [9:0] IDX_P_CDLY        = 10'h042;
  localparam logic [9:0] IDX_L_OUT_EN      = 10'h050;
  localparam logic [9:0] IDX_L_GEN         = 10'h051;
  localparam logic [9:0] IDX_L_DIV         = 10'h052;
  localparam logic [9:0] IDX_L_CLK_COARSE  = 10'h053;
  localparam logic [9:0] IDX_L_FINE_ALIGN  = 10'h055;
  localparam logic [9:0] IDX_L_RATE        = 10'h056;
  localparam logic [9:0] IDX_L_STYLE       = 10'h057;
  localparam logic [9:0] IDX_L_FDLY_LO     = 10'h058;
  localparam logic [9:0] IDX_L_FDLY_HI     = 10'h059;
  localparam logic [9:0] IDX_L_CDLY        = 10'h05A;
  localparam logic [9:0] IDX_DIFF_CTRL     = 10'h060;
  localparam logic [9:0] IDX_DIFF_FREQ     = 10'h061;
  localparam logic [9:0] IDX_FB_FINE       = 10'h063;
  localparam logic [9:0] IDX_SRC_SEL       = 10'h065;
  localparam logic [9:0] IDX_A_MULT_LO     = 10'h067;
  localparam logic [9:0] IDX_A_MULT_HI     = 10'h068;
  localparam logic [9:0] IDX_A_SCM_LO      = 10'h069;
  localparam logic [9:0] IDX_A_SCM_HI      = 10'h06A;
  localparam logic [9:0] IDX_A_FMON_LSB    = 10'h06B;

  localparam int NUM_REGS = 32;

  typedef logic [9:0] idx_t;

  // Table of mapped registers: index and reset value, slot 0 is the read-only status
  localparam idx_t REG_IDX [NUM_REGS] = '{
    IDX_LOCK_STATE, IDX_RSVD_29, IDX_P_OUT_EN, IDX_P_GEN, IDX_P_MULT_LO, IDX_P_MULT_HI,
    IDX_P_CLK_COARSE, IDX_P_FINE_ALIGN, IDX_P_RATE, IDX_P_STYLE, IDX_P_FDLY_LO,
    IDX_P_FDLY_HI, IDX_P_CDLY, IDX_L_OUT_EN, IDX_L_GEN, IDX_L_DIV, IDX_L_CLK_COARSE,
    IDX_L_FINE_ALIGN, IDX_L_RATE, IDX_L_STYLE, IDX_L_FDLY_LO, IDX_L_FDLY_HI, IDX_L_CDLY,
    IDX_DIFF_CTRL, IDX_DIFF_FREQ, IDX_FB_FINE, IDX_SRC_SEL, IDX_A_MULT_LO, IDX_A_MULT_HI,
    IDX_A_SCM_LO, IDX_A_SCM_HI, IDX_A_FMON_LSB};

  localparam logic [7:0] RST_LOCK_STATE = 8'h04;
  localparam logic [7:0] REG_RST [NUM_REGS] = '{
    RST_LOCK_STATE, 8'h03, 8'h8F, 8'h0F, 8'h00, 8'h01, 8'h00, 8'h00, 8'h05, 8'h83, 8'h00,
    8'h00, 8'h00, 8'h8F, 8'h0F, 8'h42, 8'h00, 8'h00, 8'h05, 8'h23, 8'h00, 8'h00, 8'h00,
    8'hA3, 8'h53, 8'hF5, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};

  // Slot numbers within the table
  localparam int S_LOCK = 0;
  localparam int S_P_EN = 2;
  localparam int S_P_GEN = 3;
  localparam int S_P_MLO = 4;
  localparam int S_P_MHI = 5;
  localparam int S_P_CC = 6;
  localparam int S_P_FA = 7;
  localparam int S_P_RATE = 8;
  localparam int S_P_STY = 9;
  localparam int S_P_FLO = 10;
  localparam int S_P_FHI = 11;
  localparam int S_P_CD = 12;
  localparam int S_L_EN = 13;
  localparam int S_L_GEN = 14;
  localparam int S_L_DIV = 15;
  localparam int S_L_CC = 16;
  localparam int S_L_FA = 17;
  localparam int S_L_RATE = 18;
  localparam int S_L_STY = 19;
  localparam int S_L_FLO = 20;
  localparam int S_L_FHI = 21;
  localparam int S_L_CD = 22;
  localparam int S_D_CTL = 23;
  localparam int S_D_SEL = 24;
  localparam int S_FB = 25;
  localparam int S_SRC = 26;
  localparam int S_A_MLO = 27;
  localparam int S_A_MHI = 28;
  localparam int S_A_SLO = 29;
  localparam int S_A_SHI = 30;
  localparam int S_A_FLO = 31;

  // Field positions
  localparam int EN_CLK_BIT = 0;
  localparam int EN_PULSE_BIT = 1;
  localparam int MULT_HI_W = 6;
  localparam int SRC_FIELD_W = 2;
  localparam int NUM_REFS = 3;
  localparam logic [1:0] SRC_AUTO = 2'h0;
  localparam logic [1:0] SRC_CUSTOM_A = 2'h1;
  localparam logic [1:0] SRC_CUSTOM_B = 2'h2;

  typedef struct packed {
    logic        clk_en;
    logic        pulse_en;
    logic        clk_run;
    logic        pulse_run;
    logic [7:0]  clk_coarse;
    logic [7:0]  fine_align;
    logic [7:0]  pulse_rate;
    logic [7:0]  pulse_style;
    logic [15:0] pulse_fine_delay;
    logic [7:0]  pulse_coarse_delay;
  } synth_cfg_s;

  typedef struct packed {
    logic [13:0] mult;
    logic [7:0]  single_cycle_low;
    logic [7:0]  single_cycle_high;
    logic [7:0]  freq_mon_low_lsb;
  } custom_set_s;

endpackage : synth_cfg_pkg

/* verilog/synth_output_config_regs.sv */
`timescale 1ns/1ps
// Function
// RULE1: Programmable frequency is 14-bit N times 8k
// RULE2: Programmable pulse fine delay, 16-bit, split bytes
// RULE3: Each pulse has coarse delay in 8k periods
// RULE4: Line pulse fine delay, 16-bit, split bytes
// RULE5: Enable bits for programmable clock and pulse
// RULE6: Run register gates programmable generation separately
// RULE7: Enable bits for line clock and pulse
// RULE8: Run register gates line generation
// RULE9: Line divider select resets to 42h
// RULE10: Both clocks have coarse phase, reset zero
// RULE11: Three fine align registers, feedback resets F5h
// RULE12: Pulse rate registers reset to 05h
// RULE13: Pulse style registers reset 23h and 83h
// RULE14: Differential control A3h, frequency select 53h
// RULE15: Per-reference monitor source select, reset automatic
// RULE16: Custom set A holds 14-bit N
// RULE17: Custom set A single-cycle low/high limits
// RULE18: Custom set A frequency monitor low byte
// RULE19: Lock status read-only, reads 04h at reset
// RULE20: Host leaves reserved locations at defaults
module synth_output_config_regs
  import synth_cfg_pkg::*;
(
  input  wire logic                sys_clk,
  input  wire logic                nrst,
  input  wire logic [ADDR_W-1:0]   avs_address,
  input  wire logic                avs_read,
  input  wire logic                avs_write,
  input  wire logic [DATA_W-1:0]   avs_writedata,
  input  wire logic [3:0]          avs_byteenable,
  output logic [DATA_W-1:0]        avs_readdata,
  output logic                     avs_waitrequest,
  input  wire logic [7:0]          loop_lock_state_in,
  output synth_cfg_s               prog_cfg,
  output synth_cfg_s               line_cfg,
  output logic [13:0]              prog_mult,
  output logic [7:0]               line_div_sel,
  output logic [7:0]               diff_ctrl,
  output logic [7:0]               diff_freq_sel,
  output logic [7:0]               feedback_fine,
  output logic [NUM_REFS*2-1:0]    ref_mon_source,
  output custom_set_s              custom_set_a
);

  logic             rst_sync1_ff;
  logic             rst_sync2_ff;
  logic             srst_n;
  logic [7:0]       regs_ff [NUM_REGS];
  logic             wait_ff;
  logic [DATA_W-1:0] rdata_ff;
  int               hit_slot;
  logic             wr_go;
  logic             rd_hit;

  default clocking dflt_cb @(posedge sys_clk);
  endclocking
  default disable iff (!srst_n);

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      rst_sync1_ff <= 1'b0;
      rst_sync2_ff <= 1'b0;
    end else begin
      rst_sync1_ff <= 1'b1;
      rst_sync2_ff <= rst_sync1_ff;
    end
  end
  assign srst_n = rst_sync2_ff;

  // The address is the register index itself, so the whole map up to FFh is reachable
  function automatic int slot_of(input logic [ADDR_W-1:0] a);
    int s;
    s = -1;
    for (int i = 0; i < NUM_REGS; i++) begin
      if (REG_IDX[i] == {2'b00, a}) begin
        s = i;
      end
    end
    return s;
  endfunction : slot_of

  function automatic logic [13:0] mult_of(input logic [7:0] hi, input logic [7:0] lo);
    return {hi[MULT_HI_W-1:0], lo};
  endfunction : mult_of

  function automatic synth_cfg_s cfg_of(input logic [7:0] r [NUM_REGS],
                                        input int en, input int gen, input int cc,
                                        input int fa, input int rt, input int st,
                                        input int flo, input int fhi, input int cd);
    synth_cfg_s c;
    c.clk_en             = r[en][EN_CLK_BIT];
    c.pulse_en           = r[en][EN_PULSE_BIT];
    c.clk_run            = r[gen][EN_CLK_BIT];
    c.pulse_run          = r[gen][EN_PULSE_BIT];
    c.clk_coarse         = r[cc];
    c.fine_align         = r[fa];
    c.pulse_rate         = r[rt];
    c.pulse_style        = r[st];
    c.pulse_fine_delay   = {r[fhi], r[flo]};
    c.pulse_coarse_delay = r[cd];
    return c;
  endfunction : cfg_of

  // Output stage resets to the register defaults, so no output ever shows
  // a value that the registers never held
  localparam synth_cfg_s  PROG_RST = cfg_of(REG_RST, S_P_EN, S_P_GEN, S_P_CC, S_P_FA,
                                            S_P_RATE, S_P_STY, S_P_FLO, S_P_FHI, S_P_CD);
  localparam synth_cfg_s  LINE_RST = cfg_of(REG_RST, S_L_EN, S_L_GEN, S_L_CC, S_L_FA,
                                            S_L_RATE, S_L_STY, S_L_FLO, S_L_FHI, S_L_CD);
  localparam logic [13:0] PROG_MULT_RST = mult_of(REG_RST[S_P_MHI], REG_RST[S_P_MLO]);
  localparam custom_set_s SET_A_RST = '{
    mult:              mult_of(REG_RST[S_A_MHI], REG_RST[S_A_MLO]),
    single_cycle_low:  REG_RST[S_A_SLO],
    single_cycle_high: REG_RST[S_A_SHI],
    freq_mon_low_lsb:  REG_RST[S_A_FLO]};

  assign hit_slot = slot_of(avs_address);
  // Write lands at the edge that ends the acknowledge cycle; a held request stores again every second cycle
  assign wr_go    = avs_write && !wait_ff && hit_slot > S_LOCK && avs_byteenable[0];
  assign rd_hit   = hit_slot >= 0;

  // One wait cycle, then acknowledge; gives registered read data
  always_ff @(posedge sys_clk or negedge srst_n) begin
    if (!srst_n) begin
      wait_ff  <= 1'b1;
      rdata_ff <= '0;
    end else begin
      wait_ff  <= !((avs_read || avs_write) && wait_ff);
      rdata_ff <= (avs_read && rd_hit) ? {24'h0, regs_ff[hit_slot < 0 ? 0 : hit_slot]}
                                      : '0;
    end
  end
  assign avs_waitrequest = wait_ff;
  assign avs_readdata    = rdata_ff;

  always_ff @(posedge sys_clk or negedge srst_n) begin
    if (!srst_n) begin
      for (int i = 0; i < NUM_REGS; i++) regs_ff[i] <= REG_RST[i]; // RULE9 RULE12 RULE13 RULE14
    end else begin
      regs_ff[S_LOCK] <= loop_lock_state_in; // RULE19
      if (wr_go) begin
        regs_ff[hit_slot] <= avs_writedata[7:0];
      end
    end
  end

  always_ff @(posedge sys_clk or negedge srst_n) begin
    if (!srst_n) begin
      prog_cfg <= PROG_RST;
      line_cfg <= LINE_RST;
      prog_mult <= PROG_MULT_RST; // RULE1
      line_div_sel <= REG_RST[S_L_DIV]; // RULE9
      diff_ctrl <= REG_RST[S_D_CTL]; // RULE14
      diff_freq_sel <= REG_RST[S_D_SEL]; // RULE14
      feedback_fine <= REG_RST[S_FB]; // RULE11
      ref_mon_source <= REG_RST[S_SRC][NUM_REFS*2-1:0]; // RULE15
      custom_set_a <= SET_A_RST;
    end else begin
      prog_cfg.clk_en <= regs_ff[S_P_EN][EN_CLK_BIT]; // RULE5
      prog_cfg.pulse_en <= regs_ff[S_P_EN][EN_PULSE_BIT]; // RULE5
      prog_cfg.clk_run <= regs_ff[S_P_GEN][EN_CLK_BIT]; // RULE6
      prog_cfg.pulse_run <= regs_ff[S_P_GEN][EN_PULSE_BIT]; // RULE6
      prog_cfg.clk_coarse <= regs_ff[S_P_CC]; // RULE10
      prog_cfg.fine_align <= regs_ff[S_P_FA]; // RULE11
      prog_cfg.pulse_rate <= regs_ff[S_P_RATE]; // RULE12
      prog_cfg.pulse_style <= regs_ff[S_P_STY]; // RULE13
      prog_cfg.pulse_fine_delay <= {regs_ff[S_P_FHI], regs_ff[S_P_FLO]}; // RULE2
      prog_cfg.pulse_coarse_delay <= regs_ff[S_P_CD]; // RULE3
      line_cfg.clk_en <= regs_ff[S_L_EN][EN_CLK_BIT]; // RULE7
      line_cfg.pulse_en <= regs_ff[S_L_EN][EN_PULSE_BIT]; // RULE7
      line_cfg.clk_run <= regs_ff[S_L_GEN][EN_CLK_BIT]; // RULE8
      line_cfg.pulse_run <= regs_ff[S_L_GEN][EN_PULSE_BIT]; // RULE8
      line_cfg.clk_coarse <= regs_ff[S_L_CC]; // RULE10
      line_cfg.fine_align <= regs_ff[S_L_FA]; // RULE11
      line_cfg.pulse_rate <= regs_ff[S_L_RATE]; // RULE12
      line_cfg.pulse_style <= regs_ff[S_L_STY]; // RULE13
      line_cfg.pulse_fine_delay <= {regs_ff[S_L_FHI], regs_ff[S_L_FLO]}; // RULE4
      line_cfg.pulse_coarse_delay <= regs_ff[S_L_CD]; // RULE3
      prog_mult <= {regs_ff[S_P_MHI][MULT_HI_W-1:0], regs_ff[S_P_MLO]}; // RULE1
      line_div_sel <= regs_ff[S_L_DIV]; // RULE9
      diff_ctrl <= regs_ff[S_D_CTL]; // RULE14
      diff_freq_sel <= regs_ff[S_D_SEL]; // RULE14
      feedback_fine <= regs_ff[S_FB]; // RULE11
      ref_mon_source <= regs_ff[S_SRC][NUM_REFS*2-1:0]; // RULE15
      custom_set_a.mult <= {regs_ff[S_A_MHI][MULT_HI_W-1:0], regs_ff[S_A_MLO]}; // RULE16
      custom_set_a.single_cycle_low <= regs_ff[S_A_SLO]; // RULE17
      custom_set_a.single_cycle_high <= regs_ff[S_A_SHI]; // RULE17
      custom_set_a.freq_mon_low_lsb <= regs_ff[S_A_FLO]; // RULE18
    end
  end

  a_status_readonly: assert property ( // RULE19
    avs_write && hit_slot == S_LOCK |=> regs_ff[S_LOCK] == $past(loop_lock_state_in))
    else $error("status register took a write");

  a_status_mirror: assert property ( // RULE19
    ##1 regs_ff[S_LOCK] == $past(loop_lock_state_in))
    else $error("status not sampled");

  a_write_reaches: assert property (
    wr_go |=> regs_ff[$past(hit_slot)] == $past(avs_writedata[7:0]))
    else $error("write not stored");

  a_read_value: assert property (
    avs_read && rd_hit |=> avs_readdata == {24'h0, $past(regs_ff[hit_slot])})
    else $error("read data wrong");

  a_read_unmapped: assert property (
    avs_read && !rd_hit |=> avs_readdata == '0)
    else $error("unmapped read not zero");

  a_prog_mult_join: assert property ( // RULE1
    ##1 prog_mult == {$past(regs_ff[S_P_MHI][5:0]), $past(regs_ff[S_P_MLO])})
    else $error("programmable multiplier mismatch");

  a_pfine_join: assert property ( // RULE2
    ##1 prog_cfg.pulse_fine_delay == {$past(regs_ff[S_P_FHI]), $past(regs_ff[S_P_FLO])})
    else $error("programmable pulse delay mismatch");

  a_prog_coarse_dly: assert property ( // RULE3
    ##1 prog_cfg.pulse_coarse_delay == $past(regs_ff[S_P_CD]))
    else $error("programmable coarse delay mismatch");

  a_line_coarse_dly: assert property ( // RULE3
    ##1 line_cfg.pulse_coarse_delay == $past(regs_ff[S_L_CD]))
    else $error("line coarse delay mismatch");

  a_lfine_join: assert property ( // RULE4
    ##1 line_cfg.pulse_fine_delay == {$past(regs_ff[S_L_FHI]), $past(regs_ff[S_L_FLO])})
    else $error("line pulse delay mismatch");

  a_prog_clk_en: assert property ( // RULE5
    ##1 prog_cfg.clk_en == $past(regs_ff[S_P_EN][0]))
    else $error("clock enable not forwarded");

  a_prog_pulse_en: assert property ( // RULE5
    ##1 prog_cfg.pulse_en == $past(regs_ff[S_P_EN][1]))
    else $error("pulse enable not forwarded");

  a_run_follows: assert property ( // RULE6
    ##1 prog_cfg.clk_run == $past(regs_ff[S_P_GEN][0]))
    else $error("run bit not forwarded");

  a_pulse_run: assert property ( // RULE6
    ##1 prog_cfg.pulse_run == $past(regs_ff[S_P_GEN][1]))
    else $error("pulse run bit not forwarded");

  a_line_enable: assert property ( // RULE7
    ##1 line_cfg.pulse_en == $past(regs_ff[S_L_EN][1]))
    else $error("line enable not forwarded");

  a_line_clk_en: assert property ( // RULE7
    ##1 line_cfg.clk_en == $past(regs_ff[S_L_EN][0]))
    else $error("line clock enable not forwarded");

  a_line_clk_run: assert property ( // RULE8
    ##1 line_cfg.clk_run == $past(regs_ff[S_L_GEN][0]))
    else $error("line run bit not forwarded");

  a_line_pulse_run: assert property ( // RULE8
    ##1 line_cfg.pulse_run == $past(regs_ff[S_L_GEN][1]))
    else $error("line pulse run not forwarded");

  a_line_div: assert property ( // RULE9
    ##1 line_div_sel == $past(regs_ff[S_L_DIV]))
    else $error("divider select not forwarded");

  a_prog_clk_coarse: assert property ( // RULE10
    ##1 prog_cfg.clk_coarse == $past(regs_ff[S_P_CC]))
    else $error("programmable coarse phase mismatch");

  a_line_clk_coarse: assert property ( // RULE10
    ##1 line_cfg.clk_coarse == $past(regs_ff[S_L_CC]))
    else $error("line coarse phase mismatch");

  a_prog_fine_al: assert property ( // RULE11
    ##1 prog_cfg.fine_align == $past(regs_ff[S_P_FA]))
    else $error("programmable fine align mismatch");

  a_line_fine_al: assert property ( // RULE11
    ##1 line_cfg.fine_align == $past(regs_ff[S_L_FA]))
    else $error("line fine align mismatch");

  a_fb_fine_al: assert property ( // RULE11
    ##1 feedback_fine == $past(regs_ff[S_FB]))
    else $error("feedback fine align mismatch");

  a_prog_rate: assert property ( // RULE12
    ##1 prog_cfg.pulse_rate == $past(regs_ff[S_P_RATE]))
    else $error("programmable pulse rate mismatch");

  a_line_rate: assert property ( // RULE12
    ##1 line_cfg.pulse_rate == $past(regs_ff[S_L_RATE]))
    else $error("line pulse rate mismatch");

  a_prog_style: assert property ( // RULE13
    ##1 prog_cfg.pulse_style == $past(regs_ff[S_P_STY]))
    else $error("programmable pulse style mismatch");

  a_line_style: assert property ( // RULE13
    ##1 line_cfg.pulse_style == $past(regs_ff[S_L_STY]))
    else $error("line pulse style mismatch");

  a_diff_ctrl: assert property ( // RULE14
    ##1 diff_ctrl == $past(regs_ff[S_D_CTL]))
    else $error("differential control mismatch");

  a_diff_sel: assert property ( // RULE14
    ##1 diff_freq_sel == $past(regs_ff[S_D_SEL]))
    else $error("differential select mismatch");

  a_src_select: assert property ( // RULE15
    ##1 ref_mon_source == $past(regs_ff[S_SRC][5:0]))
    else $error("monitor source mismatch");

  a_custom_mult: assert property ( // RULE16
    ##1 custom_set_a.mult[7:0] == $past(regs_ff[S_A_MLO]))
    else $error("custom set multiplier mismatch");

  a_custom_mult_hi: assert property ( // RULE16
    ##1 custom_set_a.mult[13:8] == $past(regs_ff[S_A_MHI][5:0]))
    else $error("custom set multiplier high mismatch");

  a_single_low: assert property ( // RULE17
    ##1 custom_set_a.single_cycle_low == $past(regs_ff[S_A_SLO]))
    else $error("single cycle low limit mismatch");

  a_single_high: assert property ( // RULE17
    ##1 custom_set_a.single_cycle_high == $past(regs_ff[S_A_SHI]))
    else $error("single cycle high limit mismatch");

  a_fmon_low: assert property ( // RULE18
    ##1 custom_set_a.freq_mon_low_lsb == $past(regs_ff[S_A_FLO]))
    else $error("frequency monitor limit mismatch");

  a_ack_one_wait: assert property (
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("answer late");

  a_wait_idle: assert property (
    !(avs_read || avs_write) |=> avs_waitrequest)
    else $error("acknowledge without request");


endmodule : synth_output_config_regs

/* test/synth_output_config_regs_tb_top.sv */
`timescale 1ns/1ps
module synth_output_config_regs_tb_top import synth_cfg_pkg::*;;
  typedef struct packed {logic wr; logic [7:0] idx; logic [7:0] data; logic [7:0] exp;} row_s;
  localparam int NR = 57;
  // Reserved locations are only read, never written
  localparam row_s ROWS [NR] = '{
    '{0,8'h28,0,8'h04}, '{0,8'h29,0,8'h03}, '{0,8'h36,0,8'h8F}, '{0,8'h37,0,8'h0F},
    '{0,8'h38,0,8'h00}, '{0,8'h39,0,8'h01}, '{0,8'h3A,0,8'h00}, '{0,8'h3D,0,8'h00},
    '{0,8'h3E,0,8'h05}, '{0,8'h3F,0,8'h83}, '{0,8'h2A,0,8'h00}, '{1,8'h28,8'h55,0},
    '{0,8'h28,0,8'h04}, '{1,8'h38,8'hAB,0}, '{1,8'h39,8'h3F,0}, '{0,8'h38,0,8'hAB},
    '{0,8'h39,0,8'h3F}, '{1,8'h3A,8'h5A,0}, '{0,8'h3A,0,8'h5A}, '{1,8'h3D,8'hC3,0},
    '{0,8'h3D,0,8'hC3}, '{1,8'h3E,8'h0A,0}, '{1,8'h3F,8'h11,0}, '{0,8'h3E,0,8'h0A},
    '{0,8'h3F,0,8'h11}, '{0,8'h52,0,8'h42}, '{0,8'h56,0,8'h05}, '{0,8'h57,0,8'h23},
    '{0,8'h60,0,8'hA3}, '{0,8'h61,0,8'h53}, '{0,8'h63,0,8'hF5}, '{0,8'h65,0,8'h00},
    '{0,8'h3B,0,8'h00}, '{1,8'h40,8'h34,0}, '{1,8'h41,8'h12,0}, '{1,8'h42,8'h09,0},
    '{1,8'h58,8'h78,0}, '{1,8'h59,8'h56,0}, '{1,8'h5A,8'h0A,0}, '{1,8'h65,8'h24,0},
    '{1,8'h67,8'hCD,0}, '{1,8'h68,8'h2A,0}, '{1,8'h69,8'h11,0}, '{1,8'h6A,8'h22,0},
    '{1,8'h6B,8'h33,0}, '{1,8'h52,8'h81,0}, '{1,8'h53,8'h44,0}, '{1,8'h55,8'h66,0},
    '{1,8'h56,8'h07,0}, '{1,8'h57,8'h2F,0}, '{1,8'h60,8'hA1,0}, '{1,8'h61,8'h50,0},
    '{1,8'h63,8'h01,0}, '{0,8'h41,0,8'h12}, '{0,8'h68,0,8'h2A}, '{0,8'h6B,0,8'h33},
    '{0,8'h63,0,8'h01}};
  logic                sys_clk = 1'b0;
  logic                nrst;
  logic [ADDR_W-1:0]   avs_address;
  logic                avs_read;
  logic                avs_write;
  logic [DATA_W-1:0]   avs_writedata;
  logic [3:0]          avs_byteenable;
  logic [DATA_W-1:0]   avs_readdata;
  logic                avs_waitrequest;
  logic [7:0]          lock_in;
  synth_cfg_s          prog_cfg;
  synth_cfg_s          line_cfg;
  logic [13:0]         prog_mult;
  logic [7:0]          line_div_sel;
  logic [7:0]          diff_ctrl;
  logic [7:0]          diff_freq_sel;
  logic [7:0]          feedback_fine;
  logic [5:0]          ref_mon_source;
  custom_set_s         custom_set_a;
  logic [31:0]         rd;
  int                  n_fail = 0;
  int                  samples_checked = 0;

  always #25 sys_clk = ~sys_clk;

  synth_output_config_regs uut (.sys_clk(sys_clk), .nrst(nrst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .loop_lock_state_in(lock_in), .prog_cfg(prog_cfg),
    .line_cfg(line_cfg), .prog_mult(prog_mult), .line_div_sel(line_div_sel),
    .diff_ctrl(diff_ctrl), .diff_freq_sel(diff_freq_sel), .feedback_fine(feedback_fine),
    .ref_mon_source(ref_mon_source), .custom_set_a(custom_set_a));

  task automatic final_report();
    $display("checked %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : final_report

  task automatic cmp_port(input logic [63:0] got, input logic [63:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %0t %s got %h want %h", $time, what, got, exp);
    end
  endtask : cmp_port

  task automatic cmp_rd(input logic [7:0] idx, input logic [7:0] exp);
    samples_checked++;
    if (rd !== {24'h0, exp}) begin
      n_fail++;
      $display("BAD %0t read %h got %h want %h", $time, idx, rd, exp);
    end
  endtask : cmp_rd

  task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] d,
                     input logic [3:0] be);
    int n;
    @(posedge sys_clk);
    avs_address    <= idx;
    avs_read       <= ~wr;
    avs_write      <= wr;
    avs_writedata  <= {24'h0, d};
    avs_byteenable <= be;
    for (n = 0; n < 20; n++) begin
      @(posedge sys_clk);
      if (avs_waitrequest === 1'b0) break;
    end
    if (n == 20) begin
      n_fail++;
      $display("BAD %0t bus timeout", $time);
      final_report();
    end
    rd = avs_readdata;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus

  task automatic do_reset();
    @(posedge sys_clk);
    nrst <= 1'b0;
    repeat (10) @(posedge sys_clk);
    nrst <= 1'b1;
    // Two-flop release plus one registered stage before outputs settle
    repeat (6) @(posedge sys_clk);
  endtask : do_reset

  task automatic check_reset();
    cmp_port(prog_cfg, {4'hF, 8'h00, 8'h00, 8'h05, 8'h83, 16'h0, 8'h00}, "prog cfg");
    cmp_port(line_cfg, {4'hF, 8'h00, 8'h00, 8'h05, 8'h23, 16'h0, 8'h00}, "line cfg");
    cmp_port(prog_mult, 14'h0100, "mult");
    cmp_port(line_div_sel, 8'h42, "div");
    cmp_port(diff_ctrl, 8'hA3, "diff ctrl");
    cmp_port(diff_freq_sel, 8'h53, "diff sel");
    cmp_port(feedback_fine, 8'hF5, "fb fine");
    cmp_port(ref_mon_source, 6'h00, "src sel");
    cmp_port(custom_set_a, 38'h0, "set a");
  endtask : check_reset

  initial begin
    nrst = 1'b0;
    avs_address = '0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = '0;
    avs_byteenable = 4'hF;
    lock_in = 8'h04;
    do_reset();
    check_reset();
    $display("reset outputs done");
    for (int i = 0; i < NR; i++) begin
      bus(ROWS[i].wr, ROWS[i].idx, ROWS[i].data, 4'hF);
      if (!ROWS[i].wr) cmp_rd(ROWS[i].idx, ROWS[i].exp);
    end
    repeat (2) @(posedge sys_clk);
    cmp_port(prog_mult, 14'h3FAB, "mult");
    cmp_port(prog_cfg.clk_coarse, 8'h5A, "coarse");
    cmp_port(prog_cfg.fine_align, 8'hC3, "fine");
    cmp_port({prog_cfg.pulse_rate, prog_cfg.pulse_style}, 16'h0A11, "rate style");
    cmp_port(prog_cfg.pulse_fine_delay, 16'h1234, "p fine dly");
    cmp_port(line_cfg.pulse_fine_delay, 16'h5678, "l fine dly");
    cmp_port({prog_cfg.pulse_coarse_delay, line_cfg.pulse_coarse_delay}, 16'h090A, "cdly");
    cmp_port(ref_mon_source, 6'h24, "src sel");
    cmp_port(custom_set_a, {14'h2ACD, 8'h11, 8'h22, 8'h33}, "set a");
    cmp_port(line_div_sel, 8'h81, "div");
    cmp_port({line_cfg.clk_coarse, line_cfg.fine_align}, 16'h4466, "l phase");
    cmp_port({line_cfg.pulse_rate, line_cfg.pulse_style}, 16'h072F, "l rate");
    cmp_port({diff_ctrl, diff_freq_sel}, 16'hA150, "diff");
    cmp_port(feedback_fine, 8'h01, "fb fine");
    $display("table done");
    bus(1'b1, 8'h3A, 8'h99, 4'hE);
    bus(1'b0, 8'h3A, 8'h00, 4'hF);
    cmp_rd(8'h3A, 8'h5A);
    $display("byte enable done");
    bus(1'b1, 8'h36, 8'h02, 4'hF);
    bus(1'b1, 8'h37, 8'h01, 4'hF);
    bus(1'b1, 8'h51, 8'h02, 4'hF);
    repeat (2) @(posedge sys_clk);
    cmp_port({prog_cfg.clk_en, prog_cfg.pulse_en}, 2'b01, "enable");
    cmp_port({prog_cfg.clk_run, prog_cfg.pulse_run}, 2'b10, "run");
    cmp_port({line_cfg.clk_en, line_cfg.pulse_en}, 2'b11, "line en");
    cmp_port({line_cfg.clk_run, line_cfg.pulse_run}, 2'b01, "line run");
    $display("enable run done");
    lock_in <= 8'h11;
    repeat (3) @(posedge sys_clk);
    bus(1'b0, 8'h28, 8'h00, 4'hF);
    cmp_rd(8'h28, 8'h11);
    lock_in <= 8'h04;
    $display("status done");
    do_reset();
    check_reset();
    bus(1'b0, 8'h3A, 8'h00, 4'hF);
    cmp_rd(8'h3A, 8'h00);
    $display("second reset done");
    final_report();
  end
endmodule : synth_output_config_regs_tb_top
